// >>> inc/sdc_pkg.sv
// Shared constants and helper functions for the step command decoder.
package sdc_pkg;

	// Clock rate and blink timing.
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned BLINK_PERIOD_MS  = 3000;
	localparam int unsigned FLASH_MS         = 250;
	localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
	localparam int unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned FLASH_CYC        = FLASH_MS * CYC_PER_MS;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_POSITION = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

	// Control register fields.
	localparam int unsigned CTRL_W         = 4;
	localparam int unsigned CTRL_EDGE_BIT  = 0;
	localparam int unsigned CTRL_HOLD_BIT  = 1;
	localparam int unsigned CTRL_FPOL_BIT  = 2;
	localparam int unsigned CTRL_MODE_BIT  = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h0;

	// Status register fields.
	localparam int unsigned STAT_RUN_BIT  = 0;
	localparam int unsigned STAT_OC_BIT   = 1;
	localparam int unsigned STAT_OV_BIT   = 2;
	localparam int unsigned STAT_DIS_BIT  = 3;
	localparam int unsigned STAT_HOLD_BIT = 4;

	// Interrupt status and mask fields.
	localparam int unsigned IRQ_W        = 4;
	localparam int unsigned IRQ_STEP_BIT = 0;
	localparam int unsigned IRQ_IGN_BIT  = 1;
	localparam int unsigned IRQ_OC_BIT   = 2;
	localparam int unsigned IRQ_OV_BIT   = 3;
	localparam logic [3:0]  IRQ_RESET    = 4'h0;

	// Blink codes and slot counter.
	localparam int unsigned SLOT_W      = 3;
	localparam logic [1:0]  FLASHES_OC  = 2'h1;
	localparam logic [1:0]  FLASHES_OV  = 2'h2;

	// Position counter width.
	localparam int unsigned POS_W = 16;

	// True when a word address selects the register at the given offset.
	function automatic logic sdc_hit(input logic [31:0] addr, input logic [7:0] off);
		return (addr[31:8] == 24'h000000) && (addr[7:2] == off[7:2]);
	endfunction

	// Picks the active edge of a synchronised input from the edge switch.
	function automatic logic sdc_edge(input logic cur, input logic prev, input logic fall);
		return fall ? (prev & ~cur) : (cur & ~prev);
	endfunction

endpackage

// >>> verilog/sdc_sync.sv
// Two flip-flop synchroniser for the isolated command inputs.
`timescale 1ns/1ps
`default_nettype none

module sdc_sync #(
	parameter int unsigned W = 3
) (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

// >>> verilog/sdc_step_decoder.sv
// Step command decoder with fault signalling, status lamps and an AHB-Lite register slave.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - In single-pulse mode each active step edge, chosen by switch, is one microstep.
// - In double-pulse mode each pulse on the step input moves one microstep clockwise unless a direction pulse comes in the same cycle.
// - In single-pulse mode the direction input level sets the direction of following steps.
// - In double-pulse mode each direction input pulse moves one microstep counter-clockwise unless a step pulse comes in the same cycle.
// - The drive runs only while the controller holds the disable input inactive.
// - While disabled the shaft is released unless the hold switch asks for it to stay locked.
// - The fault output switches whenever over-voltage or over-current protection is active.
// - The fault output rests low impedance and goes high on a fault; a switch inverts it.
// - The red lamp is off normally and flashes once or twice every three seconds on a fault.
// - The green lamp is lit whenever the device is powered.
// - The blink code is one flash for over-current, which wins, and two for over-voltage.
// - A tripped protection holds the fault and frees the shaft until the next power-on reset.
// - A mode switch chooses single-pulse or double-pulse command decoding.
module sdc_step_decoder #(
	parameter int unsigned BLINK_PERIOD_CYC = sdc_pkg::BLINK_PERIOD_CYC,
	parameter int unsigned FLASH_CYC        = sdc_pkg::FLASH_CYC,
	parameter int unsigned POS_W            = sdc_pkg::POS_W
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst_n,
	// AHB-Lite slave.
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output var  logic             hreadyout,
	output var  logic             hresp,
	output var  logic [31:0]      hrdata,
	// Interrupt.
	output var  logic             irq,
	// Isolated command inputs from the motion controller.
	input  wire logic             step_pulse_in,
	input  wire logic             dir_in,
	input  wire logic             drive_disable_in,
	// Protection detectors.
	input  wire logic             over_current_in,
	input  wire logic             over_voltage_in,
	// Motion core commands.
	output var  logic             step_pulse_out,
	output var  logic             step_dir_out,
	output var  logic             hold_current_out,
	// Fault output and lamps.
	output var  logic             fault_out,
	output var  logic             lamp_red_out,
	output var  logic             lamp_green_out
);

	// Synchronised command inputs and their previous values.
	logic [2:0]             sync_q;
	logic                   step_s;
	logic                   dir_s;
	logic                   dis_s;
	logic                   step_prev_r;
	logic                   dir_prev_r;
	wire  [2:0]             cmd_raw = {drive_disable_in, dir_in, step_pulse_in};

	// Register file.
	logic [sdc_pkg::CTRL_W-1:0] ctrl_r;
	logic [sdc_pkg::IRQ_W-1:0]  irq_stat_r;
	logic [sdc_pkg::IRQ_W-1:0]  irq_stat_nxt;
	logic [sdc_pkg::IRQ_W-1:0]  irq_mask_r;
	logic [POS_W-1:0]           pos_r;
	logic [POS_W-1:0]           pos_nxt;

	// Bus data phase.
	logic                   wr_pend_r;
	logic [31:0]            wr_addr_r;

	// Fault latches and blink counters.
	logic                   oc_lat_r;
	logic                   ov_lat_r;
	logic [31:0]            period_cnt_r;
	logic [31:0]            flash_cnt_r;
	logic [sdc_pkg::SLOT_W-1:0] slot_r;

	sdc_sync #(
		.W (3)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (cmd_raw),
		.q     (sync_q)
	);

	// Edges are taken only from the synchronised copies.
	assign step_s = sync_q[0];
	assign dir_s  = sync_q[1];
	assign dis_s  = sync_q[2];

	// Control switches.
	wire edge_select_switch     = ctrl_r[sdc_pkg::CTRL_EDGE_BIT];
	wire hold_on_disable_switch = ctrl_r[sdc_pkg::CTRL_HOLD_BIT];
	wire fault_polarity_switch  = ctrl_r[sdc_pkg::CTRL_FPOL_BIT];
	wire pulse_mode_switch      = ctrl_r[sdc_pkg::CTRL_MODE_BIT];

	// Command decoding.
	wire fault_lat   = oc_lat_r | ov_lat_r;
	wire run_w       = ~dis_s & ~fault_lat;
	wire step_act    = sdc_pkg::sdc_edge(step_s, step_prev_r, edge_select_switch);
	wire dir_act     = sdc_pkg::sdc_edge(dir_s, dir_prev_r, edge_select_switch);
	wire dbl_cw      = step_act & ~dir_act;
	wire dbl_ccw     = dir_act & ~step_act;
	wire req_w       = pulse_mode_switch ? (dbl_cw | dbl_ccw) : step_act;
	wire req_dir     = pulse_mode_switch ? dbl_ccw : dir_s;
	wire step_go     = run_w & req_w;
	wire step_ignore = ~run_w & req_w;

	assign pos_nxt = step_go ? (req_dir ? pos_r - 1'b1 : pos_r + 1'b1) : pos_r;

	// Shaft current: on while running, or while disabled with hold, never after a trip.
	wire hold_nxt = ~fault_lat & (~dis_s | hold_on_disable_switch);

	// Bus decode.
	wire bus_take = hsel & htrans[1] & hready;
	wire rd_take  = bus_take & ~hwrite;
	wire wr_ctrl  = wr_pend_r & sdc_pkg::sdc_hit(wr_addr_r, sdc_pkg::OFF_CTRL);
	wire wr_istat = wr_pend_r & sdc_pkg::sdc_hit(wr_addr_r, sdc_pkg::OFF_IRQ_STAT);
	wire wr_imask = wr_pend_r & sdc_pkg::sdc_hit(wr_addr_r, sdc_pkg::OFF_IRQ_MASK);

	wire [31:0] status_w = {27'h0000000, hold_current_out, dis_s, ov_lat_r, oc_lat_r, run_w};
	wire [31:0] rd_mux =
		sdc_pkg::sdc_hit(haddr, sdc_pkg::OFF_CTRL)     ? {28'h0000000, ctrl_r} :
		sdc_pkg::sdc_hit(haddr, sdc_pkg::OFF_STATUS)   ? status_w :
		sdc_pkg::sdc_hit(haddr, sdc_pkg::OFF_POSITION) ? {{(32-POS_W){1'b0}}, pos_r} :
		sdc_pkg::sdc_hit(haddr, sdc_pkg::OFF_IRQ_STAT) ? {28'h0000000, irq_stat_r} :
		sdc_pkg::sdc_hit(haddr, sdc_pkg::OFF_IRQ_MASK) ? {28'h0000000, irq_mask_r} :
		32'h00000000;

	// Interrupt events; a new event wins over a write-one clear in the same cycle.
	wire [sdc_pkg::IRQ_W-1:0] evt_w = {over_voltage_in & ~ov_lat_r, over_current_in & ~oc_lat_r,
		step_ignore, step_go};
	wire [sdc_pkg::IRQ_W-1:0] w1c_w = wr_istat ? hwdata[sdc_pkg::IRQ_W-1:0] : 4'h0;
	wire [sdc_pkg::IRQ_W-1:0] irq_mask_nxt = wr_imask ? hwdata[sdc_pkg::IRQ_W-1:0] : irq_mask_r;
	assign irq_stat_nxt = (irq_stat_r & ~w1c_w) | evt_w;

	// Blink sequencing.
	wire       period_end = (period_cnt_r == BLINK_PERIOD_CYC - 1);
	wire       flash_end  = (flash_cnt_r == FLASH_CYC - 1);
	wire [1:0] flashes    = oc_lat_r ? sdc_pkg::FLASHES_OC : sdc_pkg::FLASHES_OV;
	wire       red_nxt    = fault_lat & ~slot_r[0] & (slot_r[2:1] < flashes);

	// Synchroniser history for edge detection.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			step_prev_r <= 1'b0;
			dir_prev_r  <= 1'b0;
		end else begin
			step_prev_r <= step_s;
			dir_prev_r  <= dir_s;
		end
	end

	// Step command outputs and position.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			step_pulse_out   <= 1'b0;
			step_dir_out     <= 1'b0;
			pos_r            <= '0;
			hold_current_out <= 1'b0;
		end else begin
			step_pulse_out   <= step_go;
			step_dir_out     <= step_go ? req_dir : step_dir_out;
			pos_r            <= pos_nxt;
			hold_current_out <= hold_nxt;
		end
	end

	// Protection latches; only a reset clears them.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			oc_lat_r  <= 1'b0;
			ov_lat_r  <= 1'b0;
			fault_out <= 1'b0;
		end else begin
			oc_lat_r  <= oc_lat_r | over_current_in;
			ov_lat_r  <= ov_lat_r | over_voltage_in;
			fault_out <= fault_lat ^ fault_polarity_switch;
		end
	end

	// Lamps and blink counters, restarted at the trip.
	always_ff @(posedge clock) begin
		if (!rst_n || !fault_lat || period_end) begin
			period_cnt_r <= 32'h00000000;
			flash_cnt_r  <= 32'h00000000;
			slot_r       <= '0;
		end else begin
			period_cnt_r <= period_cnt_r + 32'h00000001;
			flash_cnt_r  <= flash_end ? 32'h00000000 : flash_cnt_r + 32'h00000001;
			slot_r       <= (flash_end && slot_r != 3'h7) ? slot_r + 3'h1 : slot_r;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lamp_red_out   <= 1'b0;
			lamp_green_out <= 1'b1;
		end else begin
			lamp_red_out   <= red_nxt;
			lamp_green_out <= 1'b1;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h00000000;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend_r <= bus_take & hwrite;
			wr_addr_r <= bus_take ? haddr : wr_addr_r;
			hrdata    <= rd_take ? rd_mux : 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Registers and interrupt line.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_r     <= sdc_pkg::CTRL_RESET;
			irq_mask_r <= sdc_pkg::IRQ_RESET;
			irq_stat_r <= sdc_pkg::IRQ_RESET;
			irq        <= 1'b0;
		end else begin
			ctrl_r     <= wr_ctrl ? hwdata[sdc_pkg::CTRL_W-1:0] : ctrl_r;
			irq_mask_r <= irq_mask_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq        <= |(irq_stat_nxt & irq_mask_nxt);
		end
	end

	default clocking cb @(posedge clock);
	endclocking

	default disable iff (!rst_n);

	AST_SINGLE_STEP: assert property (
		(!pulse_mode_switch && run_w && step_act) |=> step_pulse_out && pos_r != $past(pos_r)
	) else $error("Single-pulse active edge did not produce a step.");

	AST_DOUBLE_CW: assert property (
		(pulse_mode_switch && run_w && step_act && !dir_act) |=> step_pulse_out && !step_dir_out
	) else $error("Clockwise pulse did not step clockwise.");

	AST_SINGLE_DIR: assert property (
		(!pulse_mode_switch && step_go) |=> step_dir_out == $past(dir_s)
	) else $error("Step direction does not follow the direction level.");

	AST_DOUBLE_CCW: assert property (
		(pulse_mode_switch && run_w && dir_act && !step_act) |=> step_pulse_out && step_dir_out
	) else $error("Counter-clockwise pulse did not step counter-clockwise.");

	AST_NO_STEP_STOPPED: assert property (
		!run_w |=> !step_pulse_out && pos_r == $past(pos_r)
	) else $error("Step taken while disabled or faulted.");

	AST_DISABLE_RUN: assert property (
		dis_s |-> !run_w
	) else $error("Drive runs while the disable input is active.");

	AST_HOLD_DISABLED: assert property (
		(dis_s && !fault_lat) |=> hold_current_out == $past(hold_on_disable_switch)
	) else $error("Shaft hold while disabled does not match the switch.");

	AST_FAULT_OUT: assert property (
		(over_current_in || over_voltage_in) |-> ##2 fault_out == !$past(fault_polarity_switch)
	) else $error("Fault output did not change on a protection event.");

	AST_FAULT_REST: assert property (
		(!fault_lat && !$past(fault_lat)) |-> fault_out == $past(fault_polarity_switch)
	) else $error("Fault output not at rest level without a fault.");

	AST_RED_OFF: assert property (
		!fault_lat |=> !lamp_red_out
	) else $error("Red lamp lit without a fault.");

	AST_GREEN_ON: assert property (
		lamp_green_out
	) else $error("Green lamp off while powered.");

	AST_BLINK_CODE: assert property (
		(fault_lat && slot_r == 3'h2) |=> lamp_red_out == !$past(oc_lat_r)
	) else $error("Second flash does not match the blink code.");

	AST_FAULT_STICKY: assert property (
		fault_lat |=> fault_lat [*2] ##0 !hold_current_out
	) else $error("Fault latch cleared or shaft held after a trip.");

	AST_SYNC_LAT: assert property (
		$changed(sync_q) |-> sync_q == $past(cmd_raw, 2)
	) else $error("Synchronised input did not pass through both stages.");

endmodule

`default_nettype wire

// >>> testbench/sdc_pulse_gen.sv
// Motion controller model that drives the isolated command inputs.
`timescale 1ns/1ps
`default_nettype none

module sdc_pulse_gen (
	// Clock.
	input  wire logic clock,
	// Command lines.
	output var  logic step_pulse_in,
	output var  logic dir_in,
	output var  logic drive_disable_in
);
	initial begin
		step_pulse_in <= 1'b0;
		dir_in <= 1'b0;
		drive_disable_in <= 1'b0;
	end

	// Changes one line after an edge, then holds every line stable for five cycles.
	task automatic set_line(input int unsigned which, input logic v);
		case (which)
			0: step_pulse_in <= v;
			1: dir_in <= v;
			default: drive_disable_in <= v;
		endcase
		repeat (5) @(posedge clock);
	endtask
endmodule

`default_nettype wire

// >>> testbench/sdc_step_decoder_bench.sv
// Self-checking bench for the step command decoder.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module sdc_step_decoder_bench;
	localparam int unsigned FL  = 4;
	localparam int unsigned PER = 40;

	logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        step_pulse_in, dir_in, drive_disable_in, over_current_in, over_voltage_in;
	logic        step_pulse_out, step_dir_out, hold_current_out;
	logic        fault_out, lamp_red_out, lamp_green_out;
	int unsigned num_errors, checked, cycles, steps, red_on, s0;

	sdc_step_decoder #(.BLINK_PERIOD_CYC(PER), .FLASH_CYC(FL)) dut (
		.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.step_pulse_in(step_pulse_in), .dir_in(dir_in), .drive_disable_in(drive_disable_in),
		.over_current_in(over_current_in), .over_voltage_in(over_voltage_in),
		.step_pulse_out(step_pulse_out), .step_dir_out(step_dir_out),
		.hold_current_out(hold_current_out), .fault_out(fault_out),
		.lamp_red_out(lamp_red_out), .lamp_green_out(lamp_green_out));

	sdc_pulse_gen gen (
		.clock(clock), .step_pulse_in(step_pulse_in), .dir_in(dir_in),
		.drive_disable_in(drive_disable_in));

	initial clock = 1'b0;
	always #20 clock = ~clock;

	// Counts taken steps, lit red lamp cycles and the run length.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (step_pulse_out === 1'b1) steps <= steps + 1;
		if (lamp_red_out === 1'b1) red_on <= red_on + 1;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		if (num_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic rst();
		rst_n <= 1'b0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
	endtask

	// One AHB-Lite single word transfer; read data lands in rd.
	task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, off};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp);
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		bus(1'b1, off, d);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] off, input logic [31:0] exp);
		bus(1'b0, off, 32'h00000000);
		`CHK(nm, exp, rd);
	endtask

	task automatic pulse(input int unsigned which);
		gen.set_line(which, 1'b1);
		gen.set_line(which, 1'b0);
	endtask

	task automatic lamp(input int unsigned exp);
		int unsigned s;
		s = red_on;
		repeat (PER) @(posedge clock);
		`CHK("red lamp cycles", exp, red_on - s);
	endtask

	initial begin
		{hsel, hwrite, over_current_in, over_voltage_in} <= 4'h0;
		{haddr, hwdata, htrans, cycles, steps, red_on} <= '0;
		{num_errors, checked} = '0;
		hsize <= 3'h2;
		rst();
		`CHK("green lamp", 1'b1, lamp_green_out);
		rdchk("ctrl", sdc_pkg::OFF_CTRL, 32'h00000000);
		rdchk("status", sdc_pkg::OFF_STATUS, 32'h00000011);
		wr(8'h14, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h14, 32'h00000000);
		lamp(0);
		`CHK("fault rest", 1'b0, fault_out);
		wr(sdc_pkg::OFF_IRQ_MASK, 32'h0000000F);
		s0 = steps;
		gen.set_line(0, 1'b1);
		`CHK("rising step", s0 + 1, steps);
		`CHK("dir cw", 1'b0, step_dir_out);
		gen.set_line(0, 1'b0);
		pulse(0);
		gen.set_line(1, 1'b1);
		pulse(0);
		`CHK("dir ccw", 1'b1, step_dir_out);
		`CHK("steps single", s0 + 3, steps);
		rdchk("position", sdc_pkg::OFF_POSITION, 32'h00000001);
		`CHK("irq step", 1'b1, irq);
		rdchk("irq status", sdc_pkg::OFF_IRQ_STAT, 32'h00000001);
		wr(sdc_pkg::OFF_IRQ_STAT, 32'h0000000F);
		rdchk("irq cleared", sdc_pkg::OFF_IRQ_STAT, 32'h00000000);
		`CHK("irq low", 1'b0, irq);
		wr(sdc_pkg::OFF_CTRL, 32'h00000001);
		gen.set_line(1, 1'b0);
		s0 = steps;
		gen.set_line(0, 1'b1);
		`CHK("no step on rise", s0, steps);
		gen.set_line(0, 1'b0);
		`CHK("step on fall", s0 + 1, steps);
		wr(sdc_pkg::OFF_CTRL, 32'h00000008);
		pulse(0);
		`CHK("double cw", 1'b0, step_dir_out);
		pulse(1);
		`CHK("double ccw", 1'b1, step_dir_out);
		pulse(1);
		`CHK("steps double", s0 + 4, steps);
		rdchk("position", sdc_pkg::OFF_POSITION, 32'h00000001);
		gen.set_line(2, 1'b1);
		`CHK("released", 1'b0, hold_current_out);
		s0 = steps;
		pulse(0);
		`CHK("disabled steps", s0, steps);
		rdchk("irq ignored", sdc_pkg::OFF_IRQ_STAT, 32'h00000003);
		rdchk("position", sdc_pkg::OFF_POSITION, 32'h00000001);
		wr(sdc_pkg::OFF_CTRL, 32'h0000000A);
		repeat (3) @(posedge clock);
		`CHK("held", 1'b1, hold_current_out);
		rdchk("status dis", sdc_pkg::OFF_STATUS, 32'h00000018);
		gen.set_line(2, 1'b0);
		rdchk("status run", sdc_pkg::OFF_STATUS, 32'h00000011);
		wr(sdc_pkg::OFF_IRQ_STAT, 32'h0000000F);
		wr(sdc_pkg::OFF_IRQ_MASK, 32'h00000000);
		pulse(0);
		`CHK("irq masked", 1'b0, irq);
		rdchk("irq pending", sdc_pkg::OFF_IRQ_STAT, 32'h00000001);
		wr(sdc_pkg::OFF_IRQ_MASK, 32'h00000001);
		repeat (3) @(posedge clock);
		`CHK("irq unmasked", 1'b1, irq);
		over_voltage_in <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("fault ov", 1'b1, fault_out);
		`CHK("free shaft", 1'b0, hold_current_out);
		lamp(2 * FL);
		over_voltage_in <= 1'b0;
		s0 = steps;
		pulse(0);
		`CHK("faulted steps", s0, steps);
		`CHK("fault kept", 1'b1, fault_out);
		rdchk("status ov", sdc_pkg::OFF_STATUS, 32'h00000004);
		over_current_in <= 1'b1;
		repeat (3) @(posedge clock);
		lamp(FL);
		over_current_in <= 1'b0;
		rst();
		wr(sdc_pkg::OFF_CTRL, 32'h00000004);
		repeat (3) @(posedge clock);
		`CHK("fault rest inv", 1'b1, fault_out);
		over_current_in <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("fault oc inv", 1'b0, fault_out);
		lamp(FL);
		`CHK("green lamp", 1'b1, lamp_green_out);
		results();
	end
endmodule

`default_nettype wire
